// ===== logic/sdc_pkg.sv
// Constants shared by the system data command decoder
package sdc_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ACK_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BUFFERS = 8'h0C;
  localparam logic [7:0] ADDR_LAST = 8'h10;
  localparam int CTL_FAST_DISABLE_BIT = 0;
  localparam int CTL_RATIO_LSB = 1;
  localparam int CTL_SILO_LSB = 4;
  localparam logic CTL_FAST_DISABLE_RESET = 1'b0;
  localparam logic [1:0] CTL_RATIO_RESET = 2'h0;
  localparam logic [1:0] CTL_SILO_RESET = 2'h0;
  localparam logic [4:0] ACK_LIMIT_RESET = 5'h00;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int ADDR_BUS_WIDTH = 15;
  localparam int TYPE_BIT = 14;
  localparam int CODE_MSB = 13;
  localparam int CODE_LSB = 9;
  localparam int VICTIM_REL_BIT = 8;
  localparam int PROBE_REL_BIT = 7;
  localparam int ACK_BIT = 6;
  localparam int INDEX_MSB = 5;
  localparam int INDEX_LSB = 2;
  localparam int COMMIT_BIT = 14;
  localparam int SILO_DEPTH = 4;
  localparam logic [4:0] CODE_NOP = 5'h00;
  localparam logic [4:0] CODE_FILL_ERROR = 5'h01;
  localparam logic [4:0] CODE_OWNERSHIP_GRANT = 5'h04;
  localparam logic [4:0] CODE_OWNERSHIP_DENY = 5'h05;
  localparam logic [4:0] CODE_BARRIER_COMPLETE = 5'h06;
  localparam logic [4:0] CODE_BUFFER_FREE = 5'h07;
  localparam logic [2:0] FAMILY_DEVICE_DRIVE = 3'h2;
  localparam logic [2:0] FAMILY_CLEAN_FILL = 3'h4;
  localparam logic [2:0] FAMILY_DIRTY_FILL = 3'h5;
  localparam logic [2:0] FAMILY_SHARED_FILL = 3'h6;
  localparam logic [2:0] FAMILY_SHARED_MODIFIED_FILL = 3'h7;
  localparam logic [1:0] TAG_CLEAN = 2'h0;
  localparam logic [1:0] TAG_SHARED = 2'h1;
  localparam logic [1:0] TAG_DIRTY = 2'h2;
  localparam logic [1:0] TAG_SHARED_DIRTY = 2'h3;
  localparam logic [2:0] LAST_DATA_CYCLE = 3'h7;
  localparam logic [1:0] PROBE_EXTRA_CYCLES = 2'h3;
  typedef enum logic [2:0] {DEC_FIRST = 3'b001, DEC_SECOND = 3'b010, DEC_PROBE = 3'b100} sdc_dec_e;
  typedef enum logic [3:0] {ENG_IDLE = 4'b0001, ENG_FILL = 4'b0010, ENG_DRIVE = 4'b0100,
                            ENG_FAST = 4'b1000} sdc_eng_e;
endpackage

// ===== logic/sdc_sync.sv
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
module sdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ===== logic/sdc_silo.sv
// Receive silo: command words advance on unload strobes, tap picks the delay
`timescale 1ns/1ps
module sdc_silo (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift,
  input wire logic [sdc_pkg::ADDR_BUS_WIDTH-1:0] din,
  input wire logic [1:0] delay,
  output logic [sdc_pkg::ADDR_BUS_WIDTH-1:0] dout
);
  logic [sdc_pkg::ADDR_BUS_WIDTH-1:0] stage [sdc_pkg::SILO_DEPTH];

  genvar g;
  generate
    for (g = 0; g < sdc_pkg::SILO_DEPTH; g++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage[g] <= '0;
        end else if (shift) begin
          stage[g] <= (g == 0) ? din : stage[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign dout = stage[delay];
endmodule

// ===== logic/sdc_decoder.sv
// Two-cycle data-movement command decoder with AXI4-Lite configuration
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sdc_decoder (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [14:0] INBOUND_ADDRESS_BUS_N,
  input wire logic INBOUND_DATA_VALID_N,
  input wire logic UNLOAD_CLOCK,
  input wire logic SYSTEM_FRAME_CLOCK,
  input wire logic [63:0] SYSTEM_DATA_BUS_I,
  output logic [63:0] SYSTEM_DATA_BUS_O,
  output logic SYSTEM_DATA_BUS_OE,
  input wire logic OUTBOUND_CMD_SENT,
  output logic OUTBOUND_STALL,
  input wire logic UNCOMMITTED_EVENT,
  input wire logic PROBE_AHEAD,
  output logic BARRIER_RETIRE,
  input wire logic [15:0] VICTIM_BUFFER_SET,
  input wire logic [7:0] PROBE_BUFFER_SET,
  input wire logic FAST_DATA_REQUEST,
  output logic OUTBOUND_WRITE_HOLD,
  output logic FAST_ABORT,
  input wire logic [63:0] WRITE_DATA,
  output logic [2:0] DATA_INDEX,
  output logic [63:0] FILL_DATA,
  output logic FILL_VALID,
  output logic [2:0] FILL_INDEX,
  output logic [1:0] FILL_TAG_STATE,
  output logic FILL_ERROR,
  output logic OWNERSHIP_GRANT,
  output logic OWNERSHIP_DENY
);
  logic rst_meta;
  logic rst_n;
  logic [81:0] sync_out;
  logic [14:0] addr_word;
  logic data_valid;
  logic [63:0] data_in;
  logic unload_level;
  logic frame_level;
  logic unload_prev;
  logic frame_prev;
  logic unload_strobe;
  logic frame_rise;
  logic [1:0] phase;
  logic [1:0] ratio_mask;
  logic frame_tick;
  logic [14:0] silo_word;
  logic fast_disable;
  logic [1:0] frame_ratio_select;
  logic [1:0] receive_silo_delay;
  logic [4:0] outstanding_command_limit;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] read_mux;
  logic read_hit;
  logic write_hit;
  sdc_pkg::sdc_dec_e dec_state;
  logic [1:0] probe_skip;
  logic [4:0] data_move_code;
  logic victim_release_flag;
  logic probe_release_flag;
  logic [3:0] buffer_index;
  logic cmd_exec;
  logic cmd_commit;
  logic ack_seen;
  logic [4:0] last_code;
  logic [4:0] outstanding_count;
  logic [4:0] next_outstanding;
  logic [7:0] uncommitted_event_count;
  logic barrier_pending;
  logic [15:0] victim_valid;
  logic [7:0] probe_valid;
  logic [15:0] victim_clear;
  logic [7:0] probe_clear;
  logic is_fill;
  logic is_drive;
  sdc_pkg::sdc_eng_e eng;
  logic eng_wait;
  logic [2:0] eng_count;
  logic [1:0] eng_wrap;
  logic fast_pending;
  logic data_cycle;
  logic [2:0] cur_index;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  sdc_sync #(.WIDTH(82)) u_sync (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .din({INBOUND_ADDRESS_BUS_N, INBOUND_DATA_VALID_N, SYSTEM_DATA_BUS_I, UNLOAD_CLOCK, SYSTEM_FRAME_CLOCK}),
    .dout(sync_out)
  );

  // Address and data-valid pins are active low; decode works on true-sense copies
  assign addr_word = ~sync_out[81:67];
  assign data_valid = ~sync_out[66];
  assign data_in = sync_out[65:2];
  assign unload_level = sync_out[1];
  assign frame_level = sync_out[0];

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      unload_prev <= 1'b0;
      frame_prev <= 1'b0;
    end else begin
      unload_prev <= unload_level;
      frame_prev <= frame_level;
    end
  end

  // Unload clock acts on both of its edges
  assign unload_strobe = unload_level ^ unload_prev;
  assign frame_rise = frame_level & ~frame_prev;
  assign ratio_mask = (frame_ratio_select == 2'h0) ? 2'h0 : (frame_ratio_select == 2'h1) ? 2'h1 : 2'h3;
  assign frame_tick = unload_strobe & ((phase & ratio_mask) == 2'h0);

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else if (frame_rise) begin
      phase <= 2'h0;
    end else if (unload_strobe) begin
      phase <= phase + 2'h1;
    end
  end

  sdc_silo u_silo (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .shift(unload_strobe),
    .din(addr_word),
    .delay(receive_silo_delay),
    .dout(silo_word)
  );

  // AXI4-Lite write channel: address and data taken in either order
  assign write_hit = (aw_addr == sdc_pkg::ADDR_CONTROL) || (aw_addr == sdc_pkg::ADDR_ACK_LIMIT);
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= sdc_pkg::AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'h0};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (aw_held && w_held && !S_AXI_BVALID) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= write_hit ? sdc_pkg::AXI_OKAY : sdc_pkg::AXI_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fast_disable <= sdc_pkg::CTL_FAST_DISABLE_RESET;
      frame_ratio_select <= sdc_pkg::CTL_RATIO_RESET;
      receive_silo_delay <= sdc_pkg::CTL_SILO_RESET;
      outstanding_command_limit <= sdc_pkg::ACK_LIMIT_RESET;
    end else if (aw_held && w_held && !S_AXI_BVALID && w_strb[0]) begin
      if (aw_addr == sdc_pkg::ADDR_CONTROL) begin
        fast_disable <= w_data[sdc_pkg::CTL_FAST_DISABLE_BIT];
        frame_ratio_select <= w_data[sdc_pkg::CTL_RATIO_LSB +: 2];
        receive_silo_delay <= w_data[sdc_pkg::CTL_SILO_LSB +: 2];
      end else if (aw_addr == sdc_pkg::ADDR_ACK_LIMIT) begin
        outstanding_command_limit <= w_data[4:0];
      end
    end
  end

  always_comb begin
    read_hit = 1'b1;
    read_mux = 32'h0000_0000;
    unique case ({S_AXI_ARADDR[7:2], 2'h0})
      sdc_pkg::ADDR_CONTROL: read_mux = {26'h0, receive_silo_delay, 1'b0, frame_ratio_select, fast_disable};
      sdc_pkg::ADDR_ACK_LIMIT: read_mux = {27'h0, outstanding_command_limit};
      sdc_pkg::ADDR_STATUS: read_mux = {11'h0, eng, barrier_pending, uncommitted_event_count, 3'h0,
                                        outstanding_count};
      sdc_pkg::ADDR_BUFFERS: read_mux = {8'h0, probe_valid, victim_valid};
      sdc_pkg::ADDR_LAST: read_mux = {25'h0, FILL_TAG_STATE, last_code};
      default: read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= sdc_pkg::AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= read_mux;
      S_AXI_RRESP <= read_hit ? sdc_pkg::AXI_OKAY : sdc_pkg::AXI_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Command framing on words as they leave the silo
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dec_state <= sdc_pkg::DEC_FIRST;
      probe_skip <= 2'h0;
      data_move_code <= sdc_pkg::CODE_NOP;
      victim_release_flag <= 1'b0;
      probe_release_flag <= 1'b0;
      buffer_index <= 4'h0;
      cmd_exec <= 1'b0;
      cmd_commit <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      cmd_exec <= 1'b0;
      cmd_commit <= 1'b0;
      ack_seen <= 1'b0;
      if (unload_strobe) begin
        unique case (dec_state)
          sdc_pkg::DEC_FIRST: begin
            if (silo_word[sdc_pkg::TYPE_BIT]) begin
              dec_state <= sdc_pkg::DEC_PROBE;
              probe_skip <= sdc_pkg::PROBE_EXTRA_CYCLES;
            end else begin
              dec_state <= sdc_pkg::DEC_SECOND;
              data_move_code <= silo_word[sdc_pkg::CODE_MSB:sdc_pkg::CODE_LSB];
              victim_release_flag <= silo_word[sdc_pkg::VICTIM_REL_BIT];
              probe_release_flag <= silo_word[sdc_pkg::PROBE_REL_BIT];
              buffer_index <= silo_word[sdc_pkg::INDEX_MSB:sdc_pkg::INDEX_LSB];
              ack_seen <= silo_word[sdc_pkg::ACK_BIT];
            end
          end
          sdc_pkg::DEC_SECOND: begin
            dec_state <= sdc_pkg::DEC_FIRST;
            cmd_exec <= 1'b1;
            cmd_commit <= silo_word[sdc_pkg::COMMIT_BIT];
          end
          sdc_pkg::DEC_PROBE: begin
            probe_skip <= probe_skip - 2'h1;
            if (probe_skip == 2'h1) begin
              dec_state <= sdc_pkg::DEC_FIRST;
            end
          end
        endcase
      end
    end
  end

  // Outstanding count: sends up, acknowledges down, never below zero
  always_comb begin
    next_outstanding = outstanding_count;
    if (OUTBOUND_CMD_SENT && !ack_seen) begin
      next_outstanding = outstanding_count + 5'h01;
    end else if (!OUTBOUND_CMD_SENT && ack_seen && outstanding_count != 5'h00) begin
      next_outstanding = outstanding_count - 5'h01;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      outstanding_count <= 5'h00;
      OUTBOUND_STALL <= 1'b0;
    end else begin
      outstanding_count <= next_outstanding;
      OUTBOUND_STALL <= (outstanding_command_limit != 5'h00) && (next_outstanding >= outstanding_command_limit);
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      uncommitted_event_count <= 8'h00;
    end else if (UNCOMMITTED_EVENT && !cmd_commit) begin
      uncommitted_event_count <= uncommitted_event_count + 8'h01;
    end else if (!UNCOMMITTED_EVENT && cmd_commit && uncommitted_event_count != 8'h00) begin
      uncommitted_event_count <= uncommitted_event_count - 8'h01;
    end
  end

  // Barrier waits for the probe ahead of it and for all commits
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      barrier_pending <= 1'b0;
      BARRIER_RETIRE <= 1'b0;
      OWNERSHIP_GRANT <= 1'b0;
      OWNERSHIP_DENY <= 1'b0;
      last_code <= sdc_pkg::CODE_NOP;
    end else begin
      BARRIER_RETIRE <= barrier_pending && !PROBE_AHEAD && (uncommitted_event_count == 8'h00);
      OWNERSHIP_GRANT <= cmd_exec && (data_move_code == sdc_pkg::CODE_OWNERSHIP_GRANT);
      OWNERSHIP_DENY <= cmd_exec && (data_move_code == sdc_pkg::CODE_OWNERSHIP_DENY);
      if (cmd_exec) begin
        last_code <= data_move_code;
      end
      if (cmd_exec && data_move_code == sdc_pkg::CODE_BARRIER_COMPLETE) begin
        barrier_pending <= 1'b1;
      end else if (barrier_pending && !PROBE_AHEAD && uncommitted_event_count == 8'h00) begin
        barrier_pending <= 1'b0;
      end
    end
  end

  // Buffer release; a new fill of a buffer wins over its release
  always_comb begin
    victim_clear = 16'h0000;
    probe_clear = 8'h00;
    if (cmd_exec && data_move_code == sdc_pkg::CODE_BUFFER_FREE) begin
      victim_clear[buffer_index] = victim_release_flag;
      probe_clear[buffer_index[2:0]] = probe_release_flag;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      victim_valid <= 16'h0000;
      probe_valid <= 8'h00;
    end else begin
      victim_valid <= (victim_valid & ~victim_clear) | VICTIM_BUFFER_SET;
      probe_valid <= (probe_valid & ~probe_clear) | PROBE_BUFFER_SET;
    end
  end

  // Codes outside the defined set fall through to nothing
  assign is_fill = (data_move_code == sdc_pkg::CODE_FILL_ERROR) || data_move_code[4];
  assign is_drive = (data_move_code[4:2] == sdc_pkg::FAMILY_DEVICE_DRIVE);
  assign data_cycle = unload_strobe && (eng != sdc_pkg::ENG_IDLE) && (!eng_wait || frame_tick);
  assign cur_index = (eng == sdc_pkg::ENG_FAST) ? eng_count : {eng_count[2:1] ^ eng_wrap, eng_count[0]};

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fast_pending <= 1'b0;
    end else if (FAST_DATA_REQUEST) begin
      fast_pending <= 1'b1;
    end else if (eng == sdc_pkg::ENG_IDLE && !cmd_exec && !fast_disable) begin
      fast_pending <= 1'b0;
    end
  end

  // Data engine: fills, device drives and fast transfers
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      eng <= sdc_pkg::ENG_IDLE;
      eng_wait <= 1'b0;
      eng_count <= 3'h0;
      eng_wrap <= 2'h0;
      FAST_ABORT <= 1'b0;
      FILL_TAG_STATE <= sdc_pkg::TAG_CLEAN;
      FILL_ERROR <= 1'b0;
      DATA_INDEX <= 3'h0;
    end else begin
      FAST_ABORT <= 1'b0;
      if (cmd_exec && (is_fill || is_drive)) begin
        FAST_ABORT <= (eng == sdc_pkg::ENG_FAST);
        eng <= is_fill ? sdc_pkg::ENG_FILL : sdc_pkg::ENG_DRIVE;
        eng_wait <= 1'b1;
        eng_count <= 3'h0;
        eng_wrap <= data_move_code[1:0];
        DATA_INDEX <= {data_move_code[1:0], 1'b0};
        if (is_fill) begin
          FILL_ERROR <= (data_move_code == sdc_pkg::CODE_FILL_ERROR);
          unique case (data_move_code[4:2])
            sdc_pkg::FAMILY_DIRTY_FILL: FILL_TAG_STATE <= sdc_pkg::TAG_DIRTY;
            sdc_pkg::FAMILY_SHARED_FILL: FILL_TAG_STATE <= sdc_pkg::TAG_SHARED;
            sdc_pkg::FAMILY_SHARED_MODIFIED_FILL: FILL_TAG_STATE <= sdc_pkg::TAG_SHARED_DIRTY;
            default: FILL_TAG_STATE <= sdc_pkg::TAG_CLEAN;
          endcase
        end
      end else if (eng == sdc_pkg::ENG_IDLE && fast_pending && !fast_disable) begin
        eng <= sdc_pkg::ENG_FAST;
        eng_wait <= 1'b1;
        eng_count <= 3'h0;
        DATA_INDEX <= 3'h0;
      end else if (data_cycle && (eng != sdc_pkg::ENG_FILL || data_valid)) begin
        eng_wait <= 1'b0;
        eng_count <= eng_count + 3'h1;
        DATA_INDEX <= (eng == sdc_pkg::ENG_FAST) ? eng_count + 3'h1
                      : {(eng_count[2:1] + {1'b0, eng_count[0]}) ^ eng_wrap, ~eng_count[0]};
        if (eng_count == sdc_pkg::LAST_DATA_CYCLE) begin
          eng <= sdc_pkg::ENG_IDLE;
        end
      end
    end
  end

  // Bus pins and fill capture
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SYSTEM_DATA_BUS_O <= 64'h0000_0000_0000_0000;
      SYSTEM_DATA_BUS_OE <= 1'b0;
      FILL_DATA <= 64'h0000_0000_0000_0000;
      FILL_VALID <= 1'b0;
      FILL_INDEX <= 3'h0;
      OUTBOUND_WRITE_HOLD <= 1'b0;
    end else begin
      FILL_VALID <= 1'b0;
      OUTBOUND_WRITE_HOLD <= (eng == sdc_pkg::ENG_FAST) || (fast_pending && !fast_disable);
      if (eng == sdc_pkg::ENG_FILL || (cmd_exec && is_fill)) begin
        SYSTEM_DATA_BUS_OE <= 1'b0;
      end else if (eng == sdc_pkg::ENG_DRIVE || eng == sdc_pkg::ENG_FAST) begin
        SYSTEM_DATA_BUS_OE <= 1'b1;
      end else begin
        SYSTEM_DATA_BUS_OE <= !fast_disable;
      end
      if (data_cycle && eng != sdc_pkg::ENG_FILL) begin
        SYSTEM_DATA_BUS_O <= WRITE_DATA;
      end
      if (data_cycle && eng == sdc_pkg::ENG_FILL && data_valid) begin
        FILL_DATA <= data_in;
        FILL_VALID <= 1'b1;
        FILL_INDEX <= cur_index;
      end
    end
  end
endmodule

// ===== testbench/sdc_properties.sv
// Pin-level checks for the command decoder
`timescale 1ns/1ps
module sdc_properties (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic PROBE_AHEAD,
  input wire logic BARRIER_RETIRE,
  input wire logic OUTBOUND_WRITE_HOLD,
  input wire logic FAST_ABORT,
  input wire logic FILL_VALID,
  input wire logic [1:0] FILL_TAG_STATE,
  input wire logic SYSTEM_DATA_BUS_OE,
  input wire logic OWNERSHIP_GRANT,
  input wire logic OWNERSHIP_DENY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  AST_GRANT_DENY: assert property (!(OWNERSHIP_GRANT && OWNERSHIP_DENY)) else $error("grant with deny");
  AST_GRANT_PULSE: assert property (OWNERSHIP_GRANT |=> !OWNERSHIP_GRANT) else $error("grant too long");
  AST_RETIRE_PROBE: assert property (BARRIER_RETIRE |-> !$past(PROBE_AHEAD)) else $error("retire past probe");
  AST_RETIRE_PULSE: assert property (BARRIER_RETIRE |=> !BARRIER_RETIRE) else $error("retire too long");
  AST_ABORT_FAST: assert property (FAST_ABORT |-> $past(OUTBOUND_WRITE_HOLD)) else $error("abort idle");
  AST_FILL_PULSE: assert property (FILL_VALID |=> !FILL_VALID) else $error("fill too long");
  AST_FILL_OE: assert property (FILL_VALID |-> !SYSTEM_DATA_BUS_OE) else $error("driving in fill");
  AST_FILL_TAG: assert property (FILL_VALID |-> $stable(FILL_TAG_STATE)) else $error("tag moved");
endmodule
bind sdc_decoder sdc_properties u_props (.*);

// ===== testbench/sdc_sys_model.sv
// System controller model: two-cycle commands and fill data on the link
`timescale 1ns/1ps
module sdc_sys_model (
  output logic [14:0] INBOUND_ADDRESS_BUS_N,
  output logic INBOUND_DATA_VALID_N,
  output logic UNLOAD_CLOCK,
  output logic SYSTEM_FRAME_CLOCK,
  output logic [63:0] SYSTEM_DATA_BUS_I
);
  initial begin
    INBOUND_ADDRESS_BUS_N = 15'h7FFF;
    INBOUND_DATA_VALID_N = 1'b1;
    UNLOAD_CLOCK = 1'b0;
    SYSTEM_FRAME_CLOCK = 1'b0;
    SYSTEM_DATA_BUS_I = 64'h0;
  end
  task automatic strobe(input logic [14:0] w);
    INBOUND_ADDRESS_BUS_N <= ~w;
    #100 UNLOAD_CLOCK <= ~UNLOAD_CLOCK;
    #100;
  endtask
  // Returns after its data strobes, so later commands never overlap them
  task automatic cmd(input logic [4:0] c, input logic [2:0] fl, input logic [3:0] id, input logic k, input int nd,
                     input logic [63:0] d);
    SYSTEM_FRAME_CLOCK <= 1'b1;
    strobe({1'b0, c, fl, id, 2'h0});
    SYSTEM_FRAME_CLOCK <= 1'b0;
    strobe({k, 14'h0});
    SYSTEM_DATA_BUS_I <= d;
    INBOUND_DATA_VALID_N <= nd == 0;
    // Idle words go out in pairs so they frame as whole no-operation commands
    repeat (nd + 4) strobe(15'h0);
    INBOUND_DATA_VALID_N <= 1'b1;
    SYSTEM_DATA_BUS_I <= ~d;
  endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module tb_top;
  logic SYS_CLK = 0, ARST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
  logic S_AXI_RREADY = 0, OUTBOUND_CMD_SENT = 0, UNCOMMITTED_EVENT = 0, PROBE_AHEAD = 0, FAST_DATA_REQUEST = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, INBOUND_DATA_VALID_N, UNLOAD_CLOCK;
  logic SYSTEM_FRAME_CLOCK, SYSTEM_DATA_BUS_OE, OUTBOUND_STALL, BARRIER_RETIRE, OUTBOUND_WRITE_HOLD, FAST_ABORT;
  logic FILL_VALID, FILL_ERROR, OWNERSHIP_GRANT, OWNERSHIP_DENY;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, FILL_TAG_STATE, tg[8] = '{0, 0, 0, 0, 0, 2, 1, 3};
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, PROBE_BUFFER_SET = 0;
  logic [2:0] S_AXI_AWPROT = 0, S_AXI_ARPROT = 0, DATA_INDEX, FILL_INDEX;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, rnd = 32'h898A;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [14:0] INBOUND_ADDRESS_BUS_N;
  logic [15:0] VICTIM_BUFFER_SET = 0;
  logic [63:0] SYSTEM_DATA_BUS_I, SYSTEM_DATA_BUS_O, WRITE_DATA = 0, FILL_DATA;
  logic [75:0] q[$];
  int error_cnt = 0, checks_done = 0;
  sdc_decoder dut (.*);
  sdc_sys_model u_sys (.*);
  always #25 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) WRITE_DATA <= {rnd, ~rnd};
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Event word; index and tag mean nothing for an error fill
  function automatic logic [75:0] ev(logic [4:0] k, logic e, logic [1:0] t, logic [2:0] i, logic [63:0] d);
    return {k, e & k[0], (k[0] & !e) ? {t, i} : 5'h00, k[0] ? d : 64'h0};
  endfunction
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [75:0] e, input logic [75:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic drain;
    for (int n = 0; n < 3000 && q.size() > 0; n++) @(posedge SYS_CLK);
    if (q.size() > 0) begin
      error_cnt++;
      close_out;
    end
  endtask
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic b = 0;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_BREADY <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_RREADY <= !w;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge SYS_CLK);
      b = w ? S_AXI_BVALID === 1'b1 : S_AXI_RVALID === 1'b1;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end
    S_AXI_BREADY <= 0;
    S_AXI_RREADY <= 0;
    if (!b) begin
      error_cnt++;
      close_out;
    end
    cmp({r, w ? 32'h0 : d}, w ? {S_AXI_BRESP, 32'h0} : {S_AXI_RRESP, S_AXI_RDATA});
  endtask
  always @(posedge SYS_CLK)
    if ((FAST_ABORT | OWNERSHIP_GRANT | OWNERSHIP_DENY | BARRIER_RETIRE | FILL_VALID) === 1'b1)
      cmp(q.size() > 0 ? q.pop_front() : 76'h0, ev({FAST_ABORT, OWNERSHIP_GRANT, OWNERSHIP_DENY, BARRIER_RETIRE,
          FILL_VALID}, FILL_ERROR, FILL_TAG_STATE, FILL_INDEX, FILL_DATA));
  initial begin
    tick(8);
    ARST_N <= 1;
    tick(3);
    u_sys.strobe(15'h0); // Pairs off the zero word the silo holds from reset
    axi(0, sdc_pkg::ADDR_ACK_LIMIT, 32'h0, sdc_pkg::AXI_OKAY);
    axi(0, 8'h14, 32'h0, sdc_pkg::AXI_SLVERR);
    axi(1, sdc_pkg::ADDR_STATUS, 32'hFF, sdc_pkg::AXI_SLVERR);
    axi(1, sdc_pkg::ADDR_CONTROL, 32'h1, sdc_pkg::AXI_OKAY);
    axi(0, sdc_pkg::ADDR_CONTROL, 32'h1, sdc_pkg::AXI_OKAY);
    FAST_DATA_REQUEST <= 1;
    tick(1);
    FAST_DATA_REQUEST <= 0;
    tick(4);
    cmp(0, OUTBOUND_WRITE_HOLD);
    axi(1, sdc_pkg::ADDR_CONTROL, 32'h0, sdc_pkg::AXI_OKAY);
    axi(1, sdc_pkg::ADDR_ACK_LIMIT, 32'h2, sdc_pkg::AXI_OKAY);
    OUTBOUND_CMD_SENT <= 1;
    tick(2);
    OUTBOUND_CMD_SENT <= 0;
    tick(3);
    cmp(1, OUTBOUND_STALL);
    u_sys.cmd(sdc_pkg::CODE_NOP, 3'h1, 4'h0, 0, 0, {rnd, rnd});
    tick(4);
    cmp(0, OUTBOUND_STALL);
    $display("Registers and acknowledge done");
    rnd = lfsr(rnd);
    VICTIM_BUFFER_SET <= 16'h1 << rnd[3:0];
    PROBE_BUFFER_SET <= 8'h1 << rnd[2:0];
    tick(1);
    VICTIM_BUFFER_SET <= 0;
    PROBE_BUFFER_SET <= 0;
    for (int i = 0; i < 2; i++) begin
      u_sys.cmd(i ? sdc_pkg::CODE_BUFFER_FREE : 5'h02, 3'h6, rnd[3:0], 0, 0, 0);
      axi(0, sdc_pkg::ADDR_BUFFERS, i ? 32'h0 : {8'h0, 8'h1 << rnd[2:0], 16'h1 << rnd[3:0]}, 0);
    end
    q.push_back(ev(5'h08, 0, 0, 0, 0));
    u_sys.cmd(sdc_pkg::CODE_OWNERSHIP_GRANT, 0, 0, 0, 0, 0);
    q.push_back(ev(5'h04, 0, 0, 0, 0));
    u_sys.cmd(sdc_pkg::CODE_OWNERSHIP_DENY, 0, 0, 0, 0, 0);
    PROBE_AHEAD <= 1;
    UNCOMMITTED_EVENT <= 1;
    tick(1);
    UNCOMMITTED_EVENT <= 0;
    u_sys.cmd(sdc_pkg::CODE_BARRIER_COMPLETE, 0, 0, 1, 0, 0);
    tick(20);
    q.push_back(ev(5'h02, 0, 0, 0, 0));
    PROBE_AHEAD <= 0;
    drain;
    $display("Buffers, ownership and barrier done");
    FAST_DATA_REQUEST <= 1;
    tick(1);
    FAST_DATA_REQUEST <= 0;
    tick(4);
    cmp(1, OUTBOUND_WRITE_HOLD);
    q.push_back(ev(5'h10, 0, 0, 0, 0));
    for (int f = 3; f < 8; f++) begin
      rnd = lfsr(rnd);
      for (int n = 0; n < 8; n++) q.push_back(ev(5'h01, f == 3, tg[f], {n[2:1] ^ rnd[1:0], n[0]}, {rnd, ~rnd}));
      u_sys.cmd(f == 3 ? sdc_pkg::CODE_FILL_ERROR : {f[2:0], rnd[1:0]}, 0, 0, 0, 10, {rnd, ~rnd});
      drain;
    end
    u_sys.cmd(sdc_pkg::CODE_BUFFER_FREE, 3'h6, 4'h0, 0, 0, 0);
    u_sys.cmd({sdc_pkg::FAMILY_DEVICE_DRIVE, rnd[1:0]}, 0, 0, 0, 10, 0);
    cmp({1'b1, rnd[1:0], 1'b0, rnd, ~rnd}, {SYSTEM_DATA_BUS_OE, DATA_INDEX, SYSTEM_DATA_BUS_O});
    $display("Fills and fast abort done");
    close_out;
  end
endmodule
